// ---- core/tpg_pkg.sv ----
// Package for the test packet generator control block
package tpg_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] TPG_ADDR_CTRL = 4'h0;
    localparam logic [3:0] TPG_ADDR_PATTERN = 4'h1;
    localparam logic [3:0] TPG_ADDR_STATUS = 4'h2;
    localparam logic [15:0] TPG_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TPG_PATTERN_RESET = 16'h0000;
    localparam logic [15:0] TPG_CTRL_WMASK = 16'hFF7F;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int TPG_CHANNEL_SELECT_HI = 15;
    localparam int TPG_CHANNEL_SELECT_LO = 14;
    localparam int TPG_MODE_BIT = 13;
    localparam int TPG_BURST_BIT = 12;
    localparam int TPG_GAP_HI = 11;
    localparam int TPG_GAP_LO = 10;
    localparam int TPG_CONT_HI = 9;
    localparam int TPG_CONT_LO = 8;
    localparam int TPG_SIZE_HI = 6;
    localparam int TPG_SIZE_LO = 4;
    localparam int TPG_MUX_HI = 3;
    localparam int TPG_MUX_LO = 2;
    localparam int TPG_START_BIT = 1;
    localparam int TPG_ENABLE_BIT = 0;

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [1:0] TPG_CONT_RANDOM = 2'h0;
    localparam logic [1:0] TPG_CONT_INCR = 2'h1;
    localparam logic [1:0] TPG_CONT_PRESET = 2'h2;
    localparam logic [1:0] TPG_CONT_DEBUG = 2'h3;
    localparam logic [3:0] TPG_SRC_SYNC_TRACE = 4'h9;
    localparam logic [1:0] TPG_MUX_ZERO = 2'h0;
    localparam logic [1:0] TPG_MUX_ONE = 2'h1;
    localparam logic [2:0] TPG_SIZE_RANDOM = 3'h7;

    // Frame lengths in bytes, indexed by size code
    localparam logic [13:0] TPG_LEN_64 = 14'h0040;
    localparam logic [13:0] TPG_LEN_2048 = 14'h0800;
    localparam logic [13:0] TPG_LEN_256 = 14'h0100;
    localparam logic [13:0] TPG_LEN_4096 = 14'h1000;
    localparam logic [13:0] TPG_LEN_1024 = 14'h0400;
    localparam logic [13:0] TPG_LEN_1518 = 14'h05EE;
    localparam logic [13:0] TPG_LEN_9000 = 14'h2328;

    // Gap lengths in bit times
    localparam int TPG_GAP_BT0 = 48;
    localparam int TPG_GAP_BT1 = 96;
    localparam int TPG_GAP_BT2 = 960;
    localparam int TPG_GAP_BT3 = 9600;
    // One byte per clock: bit times to cycles
    localparam int TPG_BITS_PER_CYCLE = 8;

    localparam logic [13:0] TPG_CHUNK_PACKETS = 14'h2710;
    localparam logic [15:0] TPG_LFSR_SEED = 16'hACE1;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tpg_bus_req_type;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic sof;
        logic eof;
    } tpg_stream_type;

    typedef struct packed {
        logic [1:0] channel;
        logic [1:0] phase;
        logic [3:0] source;
        logic [1:0] sub_mode;
        logic sync_gen;
        logic trace_gen;
    } tpg_debug_cfg_type;

    typedef enum logic [3:0] {
        TPG_ST_IDLE = 4'b0001,
        TPG_ST_FRAME = 4'b0010,
        TPG_ST_GAP = 4'b0100,
        TPG_ST_DONE = 4'b1000
    } tpg_state_type;

endpackage

// ---- core/tpg_lfsr.sv ----
// Free-running pseudo-random byte source
`timescale 1ns/1ps
module tpg_lfsr
    import tpg_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] lfsr_reg;
    logic feedback;

    // Taps for a maximal 16-bit sequence
    assign feedback = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];
    assign value = lfsr_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= TPG_LFSR_SEED;
        end else if (step) begin
            lfsr_reg <= {lfsr_reg[WIDTH-2:0], feedback};
        end
    end

endmodule

// ---- core/tpg_debug_seq.sv ----
// Debug configuration sequencer for groups of four packets
`timescale 1ns/1ps
module tpg_debug_seq
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic frame_done,
    input wire logic burst_en,
    input wire logic [1:0] mux_opt,
    input wire logic [1:0] chan_sel,
    input wire logic [3:0] source,
    output tpg_debug_cfg_type cfg,
    output logic group_last
);

    logic [1:0] index_reg;
    logic auto_phase;
    logic auto_chan;

    assign auto_phase = burst_en && (mux_opt == TPG_MUX_ZERO);
    assign auto_chan = burst_en && (mux_opt == TPG_MUX_ONE);
    // Seen in the gap: index has already wrapped after the fourth packet
    assign group_last = (index_reg == 2'h0);

    // Channel select ignored in auto-channel burst
    assign cfg.channel = auto_chan ? index_reg : chan_sel;
    assign cfg.phase = auto_phase ? index_reg : 2'h0;
    assign cfg.source = source;
    // Sync/trace generation or sub-mode selection
    assign cfg.sync_gen = !burst_en && (source == TPG_SRC_SYNC_TRACE)
        && (mux_opt == TPG_MUX_ZERO);
    assign cfg.trace_gen = !burst_en && (source == TPG_SRC_SYNC_TRACE)
        && (mux_opt == TPG_MUX_ONE);
    assign cfg.sub_mode = mux_opt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_reg <= 2'h0;
        end else if (restart) begin
            index_reg <= 2'h0;
        end else if (frame_done) begin
            index_reg <= index_reg + 2'h1;
        end
    end

endmodule

// ---- core/tpg_control.sv ----
// Test packet generator control and frame sequencing
// Functional notes
// - Bits 15:14 pick debug channel A-D
// - Channel select ignored in auto-channel burst
// - Bit 13: continuous or single packet/burst
// - Bit 12 enables automatic burst-of-four configuration
// - Mux option 0 walks polyphases 0-3
// - Mux option 1 walks channels A-D
// - Burst single gives four with debug payload, else one; continuous repeats fours
// - Bits 11:10 pick gap 48/96/960/9600 bits
// - Bits 9:8 pick random/increment/preset/debug payload
// - Debug content takes its source from pattern register, channel and phase from control
// - Bit 7 reserved, reads zero
// - Bits 6:4 pick frame length
// - Length counts addresses, type, payload and check
// - Code 111 randomizes non-jumbo length
// - Bits 3:2 mux option, meaning from source
// - Source 1001: sync or trace, else sub-mode
// - Start bit with enable bit 0 set runs generation; chunks of 10000
`timescale 1ns/1ps
module tpg_control
    import tpg_pkg::*;
#(
    parameter logic [13:0] CHUNK_PACKETS = TPG_CHUNK_PACKETS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    output tpg_stream_type tx_stream,
    output tpg_debug_cfg_type debug_cfg,
    output logic running
);

    // ****************************************
    // Constants derived from gap lengths
    // ****************************************
    localparam logic [10:0] GAP_CYC0 = 11'(TPG_GAP_BT0 / TPG_BITS_PER_CYCLE);
    localparam logic [10:0] GAP_CYC1 = 11'(TPG_GAP_BT1 / TPG_BITS_PER_CYCLE);
    localparam logic [10:0] GAP_CYC2 = 11'(TPG_GAP_BT2 / TPG_BITS_PER_CYCLE);
    localparam logic [10:0] GAP_CYC3 = 11'(TPG_GAP_BT3 / TPG_BITS_PER_CYCLE);

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] ctrl_reg;
    logic [15:0] pattern_reg;
    logic [15:0] rdata_reg;
    tpg_state_type state_reg;
    tpg_state_type state_next;
    logic [13:0] byte_cnt_reg;
    logic [13:0] frame_len_reg;
    logic [13:0] pkt_cnt_reg;
    logic [10:0] gap_cnt_reg;
    logic [7:0] incr_reg;
    logic pat_sel_reg;
    tpg_stream_type stream_reg;
    tpg_debug_cfg_type dbg_reg;
    logic running_reg;
    logic start_d_reg;

    // ****************************************
    // Bus decode
    // ****************************************
    wire wr_ctrl = bus_wr && (bus_addr == TPG_ADDR_CTRL);
    wire wr_pattern = bus_wr && (bus_addr == TPG_ADDR_PATTERN);
    wire [15:0] status_word = {14'h0000, running_reg,
        state_reg != TPG_ST_IDLE};
    wire [15:0] rd_mux =
        (bus_addr == TPG_ADDR_CTRL) ? ctrl_reg :
        (bus_addr == TPG_ADDR_PATTERN) ? pattern_reg :
        (bus_addr == TPG_ADDR_STATUS) ? status_word : 16'h0000;

    // ****************************************
    // Field extraction
    // ****************************************
    wire [1:0] chan_sel = ctrl_reg[TPG_CHANNEL_SELECT_HI:TPG_CHANNEL_SELECT_LO];
    wire single_mode = ctrl_reg[TPG_MODE_BIT];
    wire burst_en = ctrl_reg[TPG_BURST_BIT];
    wire [1:0] gap_sel = ctrl_reg[TPG_GAP_HI:TPG_GAP_LO];
    wire [1:0] content = ctrl_reg[TPG_CONT_HI:TPG_CONT_LO];
    wire [2:0] size_sel = ctrl_reg[TPG_SIZE_HI:TPG_SIZE_LO];
    wire [1:0] mux_opt = ctrl_reg[TPG_MUX_HI:TPG_MUX_LO];
    wire start_bit = ctrl_reg[TPG_START_BIT];
    wire enable_bit = ctrl_reg[TPG_ENABLE_BIT];
    wire debug_sel = (content == TPG_CONT_DEBUG);
    // Debug source lives in the pattern register's low nibble
    wire [3:0] source = pattern_reg[3:0];

    // ****************************************
    // Pseudo-random source and debug sequencer
    // ****************************************
    logic [15:0] rnd;
    tpg_debug_cfg_type seq_cfg;
    logic group_last;
    wire byte_step = (state_reg == TPG_ST_FRAME);
    wire frame_end = byte_step && (byte_cnt_reg == frame_len_reg - 14'h1);
    wire go = start_bit && enable_bit;
    wire start_rise = go && !start_d_reg;

    tpg_lfsr #(
        .WIDTH(16)
    ) u_lfsr (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .step(1'b1),
        .value(rnd)
    );

    tpg_debug_seq u_seq (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .restart(start_rise),
        .frame_done(frame_end),
        .burst_en(burst_en),
        .mux_opt(mux_opt),
        .chan_sel(chan_sel),
        .source(source),
        .cfg(seq_cfg),
        .group_last(group_last)
    );

    // ****************************************
    // Frame length and gap selection
    // ****************************************
    logic [13:0] fixed_len;
    always_comb begin
        case (size_sel)
            3'h0: fixed_len = TPG_LEN_64;
            3'h1: fixed_len = TPG_LEN_2048;
            3'h2: fixed_len = TPG_LEN_256;
            3'h3: fixed_len = TPG_LEN_4096;
            3'h4: fixed_len = TPG_LEN_1024;
            3'h5: fixed_len = TPG_LEN_1518;
            3'h6: fixed_len = TPG_LEN_9000;
            default: fixed_len = TPG_LEN_1518;
        endcase
    end

    // Random pick among 256, 1024 and 1518 bytes, never jumbo
    logic [13:0] rand_len;
    always_comb begin
        case (rnd[1:0])
            2'h0: rand_len = TPG_LEN_256;
            2'h1: rand_len = TPG_LEN_1024;
            default: rand_len = TPG_LEN_1518;
        endcase
    end

    wire [13:0] next_len = (size_sel == TPG_SIZE_RANDOM) ? rand_len
        : fixed_len;

    logic [10:0] gap_cycles;
    always_comb begin
        case (gap_sel)
            2'h0: gap_cycles = GAP_CYC0;
            2'h1: gap_cycles = GAP_CYC1;
            2'h2: gap_cycles = GAP_CYC2;
            default: gap_cycles = GAP_CYC3;
        endcase
    end

    // ****************************************
    // Payload byte selection
    // ****************************************
    logic [7:0] payload;
    always_comb begin
        case (content)
            TPG_CONT_RANDOM: payload = rnd[7:0];
            TPG_CONT_INCR: payload = incr_reg;
            TPG_CONT_PRESET: payload = pat_sel_reg ? pattern_reg[15:8]
                : pattern_reg[7:0];
            default: payload = {seq_cfg.channel, seq_cfg.phase,
                seq_cfg.source};
        endcase
    end

    // ****************************************
    // Sequencing decisions
    // ****************************************
    // Single mode stops after one packet, or after a group of four
    wire single_done = single_mode && (!(burst_en && debug_sel)
        || group_last);
    wire chunk_done = (pkt_cnt_reg == CHUNK_PACKETS - 14'h1);
    wire gap_done = (gap_cnt_reg == gap_cycles - 11'h1);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TPG_ST_IDLE: begin
                if (start_rise) begin
                    state_next = TPG_ST_FRAME;
                end
            end
            TPG_ST_FRAME: begin
                if (frame_end) begin
                    state_next = TPG_ST_GAP;
                end
            end
            TPG_ST_GAP: begin
                if (!go) begin
                    state_next = TPG_ST_IDLE;
                end else if (gap_done) begin
                    state_next = single_done ? TPG_ST_DONE
                        : TPG_ST_FRAME;
                end
            end
            TPG_ST_DONE: begin
                if (!go) begin
                    state_next = TPG_ST_IDLE;
                end
            end
            default: state_next = TPG_ST_IDLE;
        endcase
    end

    // ****************************************
    // Register writes and readback
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= TPG_CTRL_RESET;
            pattern_reg <= TPG_PATTERN_RESET;
            rdata_reg <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= bus_wdata & TPG_CTRL_WMASK;
            end
            if (wr_pattern) begin
                pattern_reg <= bus_wdata;
            end
            rdata_reg <= bus_rd ? rd_mux : 16'h0000;
        end
    end

    // ****************************************
    // Frame state and counters
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= TPG_ST_IDLE;
            start_d_reg <= 1'b0;
            byte_cnt_reg <= 14'h0;
            frame_len_reg <= TPG_LEN_64;
            gap_cnt_reg <= 11'h0;
            pkt_cnt_reg <= 14'h0;
        end else begin
            state_reg <= state_next;
            start_d_reg <= go;
            if (state_next == TPG_ST_FRAME && state_reg != TPG_ST_FRAME) begin
                frame_len_reg <= next_len;
                byte_cnt_reg <= 14'h0;
            end else if (byte_step) begin
                byte_cnt_reg <= byte_cnt_reg + 14'h1;
            end
            gap_cnt_reg <= (state_reg == TPG_ST_GAP) ?
                gap_cnt_reg + 11'h1 : 11'h0;
            if (start_rise) begin
                pkt_cnt_reg <= 14'h0;
            end else if (frame_end) begin
                pkt_cnt_reg <= chunk_done ? 14'h0 : pkt_cnt_reg + 14'h1;
            end
        end
    end

    // ****************************************
    // Payload generators and stream output
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            incr_reg <= 8'h00;
            pat_sel_reg <= 1'b0;
            stream_reg <= '0;
            dbg_reg <= '0;
            running_reg <= 1'b0;
        end else begin
            incr_reg <= byte_step ? incr_reg + 8'h01 : 8'h00;
            pat_sel_reg <= byte_step ? !pat_sel_reg : 1'b0;
            stream_reg.valid <= byte_step;
            stream_reg.data <= byte_step ? payload : 8'h00;
            stream_reg.sof <= byte_step && (byte_cnt_reg == 14'h0);
            stream_reg.eof <= frame_end;
            dbg_reg <= seq_cfg;
            running_reg <= (state_next == TPG_ST_FRAME)
                || (state_next == TPG_ST_GAP);
        end
    end

    assign bus_rdata = rdata_reg;
    assign tx_stream = stream_reg;
    assign debug_cfg = dbg_reg;
    assign running = running_reg;

endmodule

// ---- sim/tpg_checker.sv ----
// Port checker for the packet generator control block
`timescale 1ns/1ps
module tpg_checker
    import tpg_pkg::*;
#(
    parameter logic [13:0] CHUNK_PACKETS = TPG_CHUNK_PACKETS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [15:0] bus_rdata,
    input wire tpg_stream_type tx_stream,
    input wire tpg_debug_cfg_type debug_cfg,
    input wire logic running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Shadow registers and frame byte count
    // ****************************************
    logic [15:0] ctrl_reg;
    logic [15:0] pat_reg;
    logic [13:0] cnt_reg;
    wire ctrl_wr = bus_wr && bus_addr == TPG_ADDR_CTRL;
    wire [13:0] cur_len = cnt_reg + 14'h0001;
    wire len_ok = cur_len == TPG_LEN_64 || cur_len == TPG_LEN_2048 ||
        cur_len == TPG_LEN_256 || cur_len == TPG_LEN_4096 ||
        cur_len == TPG_LEN_1024 || cur_len == TPG_LEN_1518 ||
        cur_len == TPG_LEN_9000;
    wire [1:0] cont = ctrl_reg[TPG_CONT_HI:TPG_CONT_LO];
    wire [7:0] dbg_byte = {debug_cfg.channel, debug_cfg.phase,
        debug_cfg.source};
    wire vld = tx_stream.valid;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= TPG_CTRL_RESET;
            pat_reg <= TPG_PATTERN_RESET;
            cnt_reg <= 14'h0000;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg <= bus_wdata & TPG_CTRL_WMASK;
            end
            if (bus_wr && bus_addr == TPG_ADDR_PATTERN) begin
                pat_reg <= bus_wdata;
            end
            if (vld) begin
                cnt_reg <= tx_stream.sof ? 14'h0001 : cur_len;
            end
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    property p_rsvd;
        bus_rd && bus_addr == TPG_ADDR_CTRL |=> bus_rdata[7] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bit read back set");

    property p_readback;
        bus_rd && bus_addr == TPG_ADDR_CTRL |=> bus_rdata == $past(ctrl_reg);
    endproperty
    a_readback: assert property (p_readback)
        else $error("control readback differs from last write");

    property p_len;
        vld && tx_stream.eof |-> len_ok;
    endproperty
    a_len: assert property (p_len)
        else $error("frame length not a legal size");

    property p_gap;
        vld && tx_stream.eof |=> !vld [*6];
    endproperty
    a_gap: assert property (p_gap)
        else $error("gap shorter than six cycles");

    property p_contig;
        vld && !tx_stream.eof |=> vld;
    endproperty
    a_contig: assert property (p_contig)
        else $error("frame broken before its last byte");

    property p_start;
        ctrl_wr && bus_wdata[1:0] == 2'b11 && ctrl_reg[1:0] != 2'b11 &&
            !running |-> ##3 (vld && tx_stream.sof);
    endproperty
    a_start: assert property (p_start)
        else $error("first byte not three cycles after start");

    property p_incr;
        vld && !tx_stream.sof && cont == TPG_CONT_INCR |->
            tx_stream.data == $past(tx_stream.data) + 8'h01;
    endproperty
    a_incr: assert property (p_incr)
        else $error("incrementing content skipped a value");

    property p_preset;
        vld && tx_stream.sof && cont == TPG_CONT_PRESET |->
            tx_stream.data == pat_reg[7:0] ##1 tx_stream.data == pat_reg[15:8];
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset content does not follow pattern");

    property p_debug;
        vld && !tx_stream.sof && !tx_stream.eof && cont == TPG_CONT_DEBUG |->
            tx_stream.data == dbg_byte && debug_cfg.source == pat_reg[3:0];
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug content does not match configuration");

    c_frame: cover property (vld && tx_stream.eof);
    c_burst: cover property (vld && tx_stream.sof && ctrl_reg[TPG_BURST_BIT]);
    c_read: cover property (bus_rd ##1 bus_rdata != 16'h0000);
endmodule

// ---- sim/tpg_tx_sink.sv ----
// Transmit datapath model: counts frames, lengths and gaps
`timescale 1ns/1ps
module tpg_tx_sink
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tpg_stream_type tx_stream,
    output logic [15:0] frames,
    output logic [15:0] last_len,
    output logic [15:0] last_gap
);
    logic [15:0] len_reg;
    logic [15:0] gap_reg;

    // Length counts every byte from first to check sequence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frames <= 16'h0000;
            last_len <= 16'h0000;
            last_gap <= 16'h0000;
            len_reg <= 16'h0000;
            gap_reg <= 16'h0000;
        end else if (tx_stream.valid) begin
            len_reg <= tx_stream.sof ? 16'h0001 : len_reg + 16'h0001;
            gap_reg <= 16'h0000;
            if (tx_stream.sof) begin
                last_gap <= gap_reg;
            end
            if (tx_stream.eof) begin
                frames <= frames + 16'h0001;
                last_len <= len_reg + 16'h0001;
            end
        end else begin
            gap_reg <= gap_reg + 16'h0001;
        end
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the packet generator control block
`timescale 1ns/1ps
module tb;
    import tpg_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] len;
        logic [15:0] gap;
    } tpg_row_type;
    logic sys_clk, rst_n, bus_wr, bus_rd, running, sof_d;
    logic [3:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata, frames, last_len, last_gap, rd_val;
    tpg_stream_type tx_stream;
    tpg_debug_cfg_type debug_cfg;
    logic [7:0] sof_bytes[$];
    int n_mismatch, comparisons, base;
    tpg_row_type rows[7] = '{
        '{16'h0003, 16'h0040, 16'h0006}, '{16'h0513, 16'h0800, 16'h000C},
        '{16'h0A23, 16'h0100, 16'h0078}, '{16'h0C33, 16'h1000, 16'h04B0},
        '{16'h0143, 16'h0400, 16'h0006}, '{16'h0653, 16'h05EE, 16'h000C},
        '{16'h0863, 16'h2328, 16'h0078}};

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    tpg_control #(.CHUNK_PACKETS(14'h0004)) i_tpg_control (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .tx_stream(tx_stream),
        .debug_cfg(debug_cfg), .running(running));
    tpg_tx_sink i_tpg_tx_sink (.sys_clk(sys_clk), .rst_n(rst_n),
        .tx_stream(tx_stream), .frames(frames), .last_len(last_len),
        .last_gap(last_gap));

    // Second byte of each frame carries the packet's debug configuration
    always @(posedge sys_clk) begin
        sof_d <= tx_stream.valid && tx_stream.sof;
        if (sof_d) sof_bytes.push_back(tx_stream.data);
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask
    task automatic go(input logic [15:0] c);
        base = frames;
        sof_bytes.delete();
        wr(TPG_ADDR_CTRL, c);
    endtask
    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (frames < base + n && k < 30000) begin
            @(posedge sys_clk);
            k++;
        end
        check("frames", n, frames - base);
    endtask
    task automatic stop(input logic [15:0] c);
        int k;
        k = 0;
        wr(TPG_ADDR_CTRL, c & 16'hFFFC);
        while (running !== 1'b0 && k < 20000) begin
            @(posedge sys_clk);
            k++;
        end
        check("running after stop", 16'h0000, {15'h0000, running});
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen hang");
        results();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        rst_n = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 4'h0;
        bus_wdata = 16'h0000;
        n_mismatch = 0;
        comparisons = 0;
        base = 0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            rd(a[3:0]);
            check("reset value", 16'h0000, rd_val);
        end
        wr(TPG_ADDR_CTRL, 16'hFFFC);
        rd(TPG_ADDR_CTRL);
        check("reserved bit", 16'hFF7C, rd_val);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        check("unmapped read", 16'h0000, rd_val);
        rd(TPG_ADDR_PATTERN);
        check("pattern untouched", 16'h0000, rd_val);
        wr(TPG_ADDR_PATTERN, 16'hA559);
        wr(TPG_ADDR_CTRL, 16'h0000);
        repeat (3) @(posedge sys_clk);
        check("sync gen", 16'h0001, {15'h0000, debug_cfg.sync_gen});
        wr(TPG_ADDR_CTRL, 16'h0004);
        repeat (3) @(posedge sys_clk);
        check("trace gen", 16'h0001, {15'h0000, debug_cfg.trace_gen});
        check("sub mode", 16'h0001, {14'h0000, debug_cfg.sub_mode});
        $display("register test done");
        foreach (rows[i]) begin
            go(rows[i].ctrl);
            wait_frames(1);
            check("frame length", rows[i].len, last_len);
            wait_frames(2);
            check("gap", rows[i].gap, last_gap);
            stop(rows[i].ctrl);
            $display("row %0d done", i);
        end
        go(16'h2003);
        wait_frames(1);
        repeat (300) @(posedge sys_clk);
        check("single count", 16'h0001, frames - base);
        stop(16'h2003);
        $display("single test done");
        wr(TPG_ADDR_PATTERN, 16'h0003);
        go(16'hF307);
        wait_frames(4);
        repeat (300) @(posedge sys_clk);
        check("burst count", 16'h0004, frames - base);
        for (int i = 0; i < 4; i++) begin
            check("channel", i, sof_bytes[i][7:6]);
            check("source", 16'h0003, sof_bytes[i][3:0]);
        end
        stop(16'hF307);
        $display("auto channel test done");
        go(16'h9303);
        wait_frames(6);
        stop(16'h9303);
        for (int i = 0; i < 6; i++) begin
            check("phase", i % 4, sof_bytes[i][5:4]);
            check("chan", 16'h0002, sof_bytes[i][7:6]);
        end
        $display("auto phase test done");
        go(16'h0073);
        for (int i = 1; i < 4; i++) begin
            wait_frames(i);
            check("random size", 16'h0001, {15'h0000, last_len == 16'h0100 ||
                last_len == 16'h0400 || last_len == 16'h05EE});
        end
        stop(16'h0073);
        base = frames;
        repeat (300) @(posedge sys_clk);
        check("frames after stop", 16'h0000, frames - base);
        $display("random size test done");
        results();
    end
endmodule

bind tpg_control tpg_checker #(.CHUNK_PACKETS(CHUNK_PACKETS)) i_tpg_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .tx_stream(tx_stream), .debug_cfg(debug_cfg),
    .running(running));
